// ---- rtl/tiv_pkg.sv ----
// constants shared by the interval timer unit: register map, control field positions, reset values, timebase rates
// assumes an 8-bit special-function register bus and a 32.768 kHz timebase level sampled on clk
// Function
// R1 - day_wrap_select picks hour wrap 23 or 255
// R2 - interval_base_sel picks interval counter tick source
// R3 - one-shot timeout clears interval_run once
// R4 - otherwise interval counter reloads every timeout
// R5 - match flag sets on equality, software clears
// R6 - interval_target compare value raises interrupt request
// R7 - interval_run enables or disables interval counter
// R8 - clock_gate_on passes or blocks timebase ticks
// R9 - gate off restores last written time values
// R10 - time registers writable as start while gated
// R11 - fraction counts 0..127, wrap advances seconds
// R12 - seconds count 0..59, wrap advances minutes
// R13 - minutes count 0..59, wrap advances hours
// R14 - hour advances hourly, 24h mode wraps 23
// R15 - all six registers read zero after reset
// R16 - interval counter steps on selected overflow
// R17 - time counting runs from 32.768 kHz timebase
// R18 - interval counter clears when stopped or reloaded
package tiv_pkg;

  // =====================================================================
  // register addresses on the special-function register bus
  localparam logic [7:0] ADDR_TICK_CONTROL    = 8'hA1;
  localparam logic [7:0] ADDR_FRACTION_COUNT  = 8'hA2;
  localparam logic [7:0] ADDR_ONE_HZ_COUNT    = 8'hA3;
  localparam logic [7:0] ADDR_SIXTY_S_COUNT   = 8'hA4;
  localparam logic [7:0] ADDR_HOUR_COUNT      = 8'hA5;
  localparam logic [7:0] ADDR_INTERVAL_TARGET = 8'hA6;

  // =====================================================================
  // tick_control field positions
  localparam int BIT_DAY_WRAP_SELECT  = 6;
  localparam int BIT_BASE_SEL_HI      = 5;
  localparam int BIT_BASE_SEL_LO      = 4;
  localparam int BIT_ONE_SHOT_SELECT  = 3;
  localparam int BIT_MATCH_FLAG       = 2;
  localparam int BIT_INTERVAL_RUN     = 1;
  localparam int BIT_CLOCK_GATE_ON    = 0;

  // =====================================================================
  // reset values
  localparam logic [7:0] RST_TICK_CONTROL    = 8'h00;
  localparam logic [7:0] RST_TIME            = 8'h00;
  localparam logic [7:0] RST_INTERVAL_TARGET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // =====================================================================
  // counter limits (last value before wrap)
  localparam logic [7:0] LIM_FRACTION  = 8'h7F;
  localparam logic [7:0] LIM_SECONDS   = 8'h3B;
  localparam logic [7:0] LIM_MINUTES   = 8'h3B;
  localparam logic [7:0] LIM_HOUR_DAY  = 8'h17;
  localparam logic [7:0] LIM_HOUR_FREE = 8'hFF;
  localparam int         NUM_TIME_CNT  = 4;

  // =====================================================================
  // timebase rates: crystal edges per 1/128 s step
  localparam int         TIMEBASE_HZ   = 32768;
  localparam int         FRACTION_HZ   = 128;
  localparam int         PRESCALE_DIV  = TIMEBASE_HZ / FRACTION_HZ;
  localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE_DIV - 1);

  // interval timebase selection codes
  typedef enum logic [1:0] {
    TIV_BASE_FRACTION = 2'h0,
    TIV_BASE_SECONDS  = 2'h1,
    TIV_BASE_MINUTES  = 2'h2,
    TIV_BASE_HOURS    = 2'h3
  } tiv_base_t;

endpackage

// ---- rtl/tiv_cnt_if.sv ----
// carrier between the timer top and one wrapping time counter
// assumes both ends run on the same clk
`timescale 1ns/1ps
interface tiv_cnt_if;
  logic       tick;
  logic       restore;
  logic [7:0] limit;
  logic [7:0] restore_val;
  logic [7:0] count;
  logic       wrap;

  modport ctrl (output tick, output restore, output limit, output restore_val, input count, input wrap);
  modport cnt  (input tick, input restore, input limit, input restore_val, output count, output wrap);
endinterface

// ---- rtl/tiv_wrap_cnt.sv ----
// one wrapping time counter: counts 0..limit on tick, reloads a given value on restore
// assumes tick is a one-cycle pulse on clk and limit is stable between ticks
`timescale 1ns/1ps
module tiv_wrap_cnt
  import tiv_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  tiv_cnt_if.cnt    bus
);

  logic [7:0] count;
  logic       at_limit;

  // =====================================================================
  // wrap detection; >= so a software value above the limit still rolls over
  assign at_limit = (count >= bus.limit);
  assign bus.wrap  = bus.tick & at_limit & ~bus.restore;
  assign bus.count = count;

  // restore beats tick so a software load is never overwritten by a step
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count <= RST_TIME;                    // [R15]
    end else if (bus.restore) begin
      count <= bus.restore_val;             // [R9] [R10]
    end else if (bus.tick) begin
      count <= at_limit ? 8'h00 : count + 8'h01;
    end
  end

endmodule

// ---- rtl/tiv_top.sv ----
// interval timer unit: real-time chain (fraction, seconds, minutes, hours) plus an 8-bit interval counter
// assumes the core drives a byte-wide special-function register bus on clk and a 32.768 kHz level on timebase_in
`timescale 1ns/1ps
module tiv_top
  import tiv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       timebase_in,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            interval_irq
);

  // =====================================================================
  // register state
  logic       day_wrap_select;
  logic [1:0] interval_base_sel;
  logic       one_shot_select;
  logic       interval_match_flag;
  logic       interval_run;
  logic       clock_gate_on;
  logic [7:0] interval_target;
  logic [7:0] interval_count;
  logic [7:0] shadow [NUM_TIME_CNT];
  logic       timebase_q;
  logic [7:0] prescale;

  // =====================================================================
  // address decode
  wire sel_ctrl   = (sfr_addr == ADDR_TICK_CONTROL);
  wire sel_target = (sfr_addr == ADDR_INTERVAL_TARGET);
  wire wr_ctrl    = sfr_wr & sel_ctrl;
  wire wr_target  = sfr_wr & sel_target;

  logic [7:0] time_addr [NUM_TIME_CNT];
  assign time_addr[0] = ADDR_FRACTION_COUNT;
  assign time_addr[1] = ADDR_ONE_HZ_COUNT;
  assign time_addr[2] = ADDR_SIXTY_S_COUNT;
  assign time_addr[3] = ADDR_HOUR_COUNT;

  // =====================================================================
  // timebase: edges of the slow crystal level step a divide-by-256 prescaler
  wire timebase_edge = timebase_in & ~timebase_q;
  wire prescale_end  = (prescale == PRESCALE_LAST);
  wire tick_128      = clock_gate_on & timebase_edge & prescale_end;   // [R8] [R17]

  // prescaler held clear while gated so a restart begins a full 1/128 s step
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timebase_q <= 1'b0;
      prescale   <= 8'h00;
    end else begin
      timebase_q <= timebase_in;
      if (!clock_gate_on) begin
        prescale <= 8'h00;                                             // [R8]
      end else if (timebase_edge) begin
        prescale <= prescale_end ? 8'h00 : prescale + 8'h01;           // [R17]
      end
    end
  end

  // =====================================================================
  // time counter chain
  tiv_cnt_if cif [NUM_TIME_CNT] ();

  logic [NUM_TIME_CNT-1:0] cnt_wrap;
  logic [NUM_TIME_CNT-1:0] cnt_tick;
  logic [NUM_TIME_CNT-1:0] wr_time;
  logic [7:0]              cnt_limit [NUM_TIME_CNT];
  logic [7:0]              cnt_value [NUM_TIME_CNT];

  // fraction counter steps on tick_128, each other counter on the wrap of the one below it
  assign cnt_tick = {cnt_wrap[2], cnt_wrap[1], cnt_wrap[0], tick_128};        // [R11] [R12] [R13] [R14]
  assign cnt_limit[0] = LIM_FRACTION;                                         // [R11]
  assign cnt_limit[1] = LIM_SECONDS;                                          // [R12]
  assign cnt_limit[2] = LIM_MINUTES;                                          // [R13]
  assign cnt_limit[3] = day_wrap_select ? LIM_HOUR_DAY : LIM_HOUR_FREE;       // [R1] [R14]

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIME_CNT; gi++) begin : g_time
      assign wr_time[gi]          = sfr_wr & (sfr_addr == time_addr[gi]);
      assign cif[gi].tick         = cnt_tick[gi];
      assign cif[gi].limit        = cnt_limit[gi];
      // gate low keeps counters pinned to the last written value
      assign cif[gi].restore      = ~clock_gate_on | wr_time[gi];             // [R9] [R10]
      assign cif[gi].restore_val  = wr_time[gi] ? sfr_wdata : shadow[gi];     // [R9] [R10]
      assign cnt_wrap[gi]         = cif[gi].wrap;
      assign cnt_value[gi]        = cif[gi].count;

      tiv_wrap_cnt u_cnt (
        .clk  (clk),
        .rstn (rstn),
        .bus  (cif[gi])
      );

      // last value software wrote, restored whenever the gate drops
      always_ff @(posedge clk) begin
        if (!rstn) begin
          shadow[gi] <= RST_TIME;                                             // [R15]
        end else if (wr_time[gi]) begin
          shadow[gi] <= sfr_wdata;                                            // [R9]
        end
      end
    end
  endgenerate

  // =====================================================================
  // interval counter: tick source selected among the chain's overflows
  logic interval_tick_src;
  always_comb begin
    case (tiv_base_t'(interval_base_sel))                                     // [R2] [R16]
      TIV_BASE_FRACTION: interval_tick_src = tick_128;
      TIV_BASE_SECONDS:  interval_tick_src = cnt_wrap[0];
      TIV_BASE_MINUTES:  interval_tick_src = cnt_wrap[1];
      TIV_BASE_HOURS:    interval_tick_src = cnt_wrap[2];
      default:           interval_tick_src = 1'b0;
    endcase
  end

  wire       interval_tick    = interval_run & interval_tick_src;             // [R7]
  wire [7:0] interval_step    = interval_count + 8'h01;
  // a target of zero matches only after the count rolls past 255
  wire       interval_timeout = interval_tick & (interval_step == interval_target); // [R5] [R6]

  // stopped counter sits at zero; each timeout reloads to zero for a full period
  always_ff @(posedge clk) begin
    if (!rstn) begin
      interval_count <= 8'h00;
    end else if (!interval_run || interval_timeout) begin
      interval_count <= 8'h00;                                                // [R18] [R4]
    end else if (interval_tick) begin
      interval_count <= interval_step;                                        // [R16]
    end
  end

  // =====================================================================
  // tick_control and interval_target registers
  logic next_match_flag;
  logic next_interval_run;

  // hardware set wins over a software clear in the same cycle
  assign next_match_flag = interval_timeout |
                           (wr_ctrl ? sfr_wdata[BIT_MATCH_FLAG] : interval_match_flag); // [R5]

  // a software write of the run bit takes precedence over the one-shot stop
  assign next_interval_run = wr_ctrl ? sfr_wdata[BIT_INTERVAL_RUN] :
                             (interval_timeout & one_shot_select) ? 1'b0 : interval_run; // [R3] [R7]

  always_ff @(posedge clk) begin
    if (!rstn) begin
      day_wrap_select     <= RST_TICK_CONTROL[BIT_DAY_WRAP_SELECT];           // [R15]
      interval_base_sel   <= RST_TICK_CONTROL[BIT_BASE_SEL_HI:BIT_BASE_SEL_LO];
      one_shot_select     <= RST_TICK_CONTROL[BIT_ONE_SHOT_SELECT];
      interval_match_flag <= RST_TICK_CONTROL[BIT_MATCH_FLAG];
      interval_run        <= RST_TICK_CONTROL[BIT_INTERVAL_RUN];
      clock_gate_on       <= RST_TICK_CONTROL[BIT_CLOCK_GATE_ON];
      interval_target     <= RST_INTERVAL_TARGET;
    end else begin
      interval_match_flag <= next_match_flag;
      interval_run        <= next_interval_run;
      if (wr_ctrl) begin
        day_wrap_select   <= sfr_wdata[BIT_DAY_WRAP_SELECT];                  // [R1]
        interval_base_sel <= sfr_wdata[BIT_BASE_SEL_HI:BIT_BASE_SEL_LO];      // [R2]
        one_shot_select   <= sfr_wdata[BIT_ONE_SHOT_SELECT];                  // [R3] [R4]
        clock_gate_on     <= sfr_wdata[BIT_CLOCK_GATE_ON];                    // [R8]
      end
      if (wr_target) begin
        interval_target   <= sfr_wdata;                                       // [R6]
      end
    end
  end

  // =====================================================================
  // read mux; bit 7 of tick_control is reserved and reads zero
  wire [7:0] ctrl_value = {1'b0, day_wrap_select, interval_base_sel, one_shot_select,
                           interval_match_flag, interval_run, clock_gate_on};

  logic [7:0] read_value;
  always_comb begin
    read_value = READ_UNMAPPED;
    if (sel_ctrl) begin
      read_value = ctrl_value;
    end else if (sel_target) begin
      read_value = interval_target;
    end
    for (int k = 0; k < NUM_TIME_CNT; k++) begin
      if (sfr_addr == time_addr[k]) begin
        read_value = cnt_value[k];
      end
    end
  end

  // read data registered, held between reads
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sfr_rdata <= READ_UNMAPPED;
    end else if (sfr_rd) begin
      sfr_rdata <= read_value;
    end
  end

  // interrupt request level; enabling it is the core interrupt logic's job
  assign interval_irq = interval_match_flag;                                  // [R6]

endmodule

// ---- sim/tiv_chk.sv ----
// checker for the interval timer unit: register bus answers and match flag behaviour
// assumes it is bound to tiv_top and sees only that module's ports
`timescale 1ns/1ps
module tiv_chk
  import tiv_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       timebase_in,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       interval_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // =====================================================================
  // helpers
  logic       tb_prev;
  wire        ctl_wr   = sfr_wr && sfr_addr == ADDR_TICK_CONTROL;
  wire        tb_quiet = !(timebase_in && !tb_prev);  // no rising timebase edge here, so no tick can land

  // previous timebase sample; a 0 then 1 pair is the only edge the counters take
  always_ff @(posedge clk) begin
    tb_prev <= timebase_in;
  end

  sequence s_wr_target;
    sfr_wr && sfr_addr == ADDR_INTERVAL_TARGET;
  endsequence
  sequence s_rd_target;
    sfr_rd && !sfr_wr && sfr_addr == ADDR_INTERVAL_TARGET;
  endsequence

  // =====================================================================
  // assertions
  a_reset_zero: assert property ($past(rstn) == 1'b0 |-> sfr_rdata == 8'h00 && !interval_irq)
    else $error("outputs not zero after reset");
  a_flag_wr_set: assert property (ctl_wr && sfr_wdata[2] |=> interval_irq)
    else $error("flag write of one not taken");
  a_flag_wr_clr: assert property (ctl_wr && !sfr_wdata[2] && tb_quiet |=> !interval_irq)
    else $error("flag clear by software not taken");
  a_flag_sticky: assert property (interval_irq && !ctl_wr |=> interval_irq)
    else $error("flag dropped without software clear");
  a_flag_cause: assert property ($rose(interval_irq) |-> $past(ctl_wr) || !$past(tb_quiet))
    else $error("flag rose with no tick and no write");
  a_rd_unmapped: assert property (sfr_rd && (sfr_addr < ADDR_TICK_CONTROL || sfr_addr > ADDR_INTERVAL_TARGET)
    |=> sfr_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  a_ctl_bit7: assert property (sfr_rd && sfr_addr == ADDR_TICK_CONTROL |=> !sfr_rdata[7])
    else $error("reserved control bit reads one");
  a_target_back: assert property (s_wr_target ##1 s_rd_target |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("target readback differs from write");
endmodule

bind tiv_top tiv_chk u_chk (.clk(clk), .rstn(rstn), .timebase_in(timebase_in), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .interval_irq(interval_irq));

// ---- sim/tb_tiv_top.sv ----
// self-checking bench for the interval timer unit, register calls with expected values
// assumes tiv_top with a one-cycle strobe register bus; timebase toggles every 2 clk here
`timescale 1ns/1ps
module tb_tiv_top
  import tiv_pkg::*;
;
  logic       clk, rstn, timebase_in, sfr_wr, sfr_rd, interval_irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [1:0] tb_div;
  int         num_errors, checks_done, cycles;

  tiv_top uut (.clk(clk), .rstn(rstn), .timebase_in(timebase_in), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .interval_irq(interval_irq));

  // =====================================================================
  // clock, timebase (period 4 clk: 1024 clk per fraction step) and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tb_div <= tb_div + 2'h1;
    timebase_in <= tb_div[1];
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      $display("MISMATCH run length expected below 40000 seen %0d", cycles);
      end_sim();
    end
  end

  // =====================================================================
  // access tasks; each starts and ends just after a rising edge
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, sfr_rdata);
    @(posedge clk);
  endtask
  // wait n cycles then look at the flag output
  task automatic irq_is(input int n, input logic e);
    repeat (n) @(posedge clk);
    #1 chk("interval_irq", {7'h00, e}, {7'h00, interval_irq});
    @(posedge clk);
  endtask
  task automatic set_time(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
    wr(ADDR_FRACTION_COUNT, f);
    wr(ADDR_ONE_HZ_COUNT, s);
    wr(ADDR_SIXTY_S_COUNT, m);
    wr(ADDR_HOUR_COUNT, h);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // =====================================================================
  // test sequence
  initial begin
    logic [7:0] tv [4];
    tv = '{8'h7F, 8'h3B, 8'h3B, 8'h17};
    {rstn, sfr_wr, sfr_rd, timebase_in, tb_div, sfr_addr, sfr_wdata} = '0;
    {num_errors, checks_done, cycles} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 'hA0; a <= 'hA7; a++) rd(8'(a), 8'h00);
    $display("test reset values done");
    wr(ADDR_TICK_CONTROL, 8'hFC);
    rd(ADDR_TICK_CONTROL, 8'h7C);
    irq_is(0, 1'b1);
    wr(ADDR_TICK_CONTROL, 8'h00);
    irq_is(0, 1'b0);
    sfr_addr <= ADDR_INTERVAL_TARGET;
    sfr_wdata <= 8'hFF;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    rd(ADDR_INTERVAL_TARGET, 8'hFF);
    wr(8'hA7, 8'h55);
    rd(8'hA7, 8'h00);
    $display("test register access done");
    // whole chain wraps on one fraction step, 24 hour mode
    set_time(8'h7F, 8'h3B, 8'h3B, 8'h17);
    wr(ADDR_TICK_CONTROL, 8'h41);
    repeat (1536) @(posedge clk);
    for (int i = 0; i < 4; i++) rd(ADDR_FRACTION_COUNT + 8'(i), 8'h00);
    irq_is(0, 1'b0);
    wr(ADDR_TICK_CONTROL, 8'h00);
    for (int i = 0; i < 4; i++) rd(ADDR_FRACTION_COUNT + 8'(i), tv[i]);
    repeat (1536) @(posedge clk);
    rd(ADDR_FRACTION_COUNT, 8'h7F);
    wr(ADDR_TICK_CONTROL, 8'h01);
    repeat (1536) @(posedge clk);
    rd(ADDR_HOUR_COUNT, 8'h18);
    $display("test time chain done");
    // periodic interval, target 2 on fraction steps
    wr(ADDR_TICK_CONTROL, 8'h00);
    wr(ADDR_INTERVAL_TARGET, 8'h02);
    wr(ADDR_TICK_CONTROL, 8'h03);
    irq_is(1536, 1'b0);
    irq_is(1022, 1'b1);
    wr(ADDR_TICK_CONTROL, 8'h03);
    irq_is(0, 1'b0);
    irq_is(2044, 1'b1);
    rd(ADDR_TICK_CONTROL, 8'h07);
    // one-shot stops itself; cleared run keeps the flag down
    wr(ADDR_TICK_CONTROL, 8'h00);
    wr(ADDR_INTERVAL_TARGET, 8'h01);
    wr(ADDR_TICK_CONTROL, 8'h0B);
    repeat (1536) @(posedge clk);
    rd(ADDR_TICK_CONTROL, 8'h0D);
    wr(ADDR_TICK_CONTROL, 8'h09);
    irq_is(2048, 1'b0);
    $display("test interval modes done");
    // each timebase selection: the chosen source reaches target 1; the first fraction step alone does not for sel 1..3
    for (int sel = 0; sel < 4; sel++) begin
      wr(ADDR_TICK_CONTROL, 8'h00);
      set_time(8'h7E, (sel >= 2) ? 8'h3B : 8'h00, (sel == 3) ? 8'h3B : 8'h00, 8'h00);
      wr(ADDR_INTERVAL_TARGET, 8'h01);
      wr(ADDR_TICK_CONTROL, {2'b00, 2'(sel), 4'h3});
      irq_is(1536, sel == 0);
      irq_is(1022, 1'b1);
    end
    $display("test timebase select done");
    end_sim();
  end
endmodule
